// ### inc/suart_pkg.sv
// Purpose: shared constants and types for the dual serial controller
// Assumes: 125 MHz ref_clk, 8-bit register port per channel
// Notes:   offsets follow the classic eight-register serial model
package suart_pkg;
  localparam logic [2:0] OFS_BUF = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_IIR = 3'h2;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] IER_WMASK = 8'h87;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam int TO_CHARS = 4;
  localparam int CHAR_BITS = 10;
  localparam int OVS = 16;
  localparam logic [9:0] TO_TICKS = 10'(TO_CHARS * CHAR_BITS * OVS);
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_RLS = 4'h6;
  localparam logic [3:0] IID_RDA = 4'h4;
  localparam logic [3:0] IID_CTO = 4'hC;
  localparam logic [3:0] IID_TX_HOLDING_EMPTY = 4'h2;
  localparam logic [4:0] TET_LVL0 = 5'h00;
  localparam logic [4:0] TET_LVL1 = 5'h02;
  localparam logic [4:0] TET_LVL2 = 5'h04;
  localparam logic [4:0] TET_LVL3 = 5'h08;
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0E;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} suart_ser_e;
endpackage

// ### hdl/suart.sv
// Purpose: two serial channels with FIFOs behind 8-bit register ports
// Assumes: one clock, pins sampled through three flops
// Notes:   stop length two when selected, also for five data bits
`timescale 1ns/1ps
`default_nettype none

module suart_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [CW-1:0]    count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [CW-1:0]    cnt_r;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready  = cnt_r != CW'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
  assign count     = cnt_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (clr) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= next_ptr(wp_r);
      end
      if (pop) begin
        rp_r <= next_ptr(rp_r);
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n) cnt_r <= CW'(DEPTH))
    else $error("fifo count above depth");
endmodule

module suart_chan import suart_pkg::*; #(
  parameter int DEPTH = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rx_pin,
  output logic            txd_r,
  output logic            irq_r
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [7:0]  lcr_r, dll_r, dlm_r, scr_r, ier_r;
  logic [1:0]  mcr_r, tet_r, trig_r;
  logic        fifo_en_r, oe_r, tick_r;
  logic [15:0] div, bcnt_r;
  logic        divisor_latch_access, wr_thr, wr_fcr, rd_rbr, rd_lsr, rx_clr, tx_clr;
  logic        tx_iv, tx_ir, tx_ov, tx_pop, rx_iv, rx_ir, rx_ov, rx_push, overrun;
  logic [7:0]  tx_od, dmask;
  logic [9:0]  rx_od;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic [3:0]  nbits, iid;
  suart_ser_e  tx_st_r, rx_st_r;
  logic [3:0]  tx_cnt_r, rx_cnt_r, tx_bit_r, rx_bit_r;
  logic [7:0]  tx_sh_r, rx_sh_r;
  logic        tx_par_r, tx_stop2_r, rx_par_r, rx_pe_r;
  logic [2:0]  rx_s_r;
  logic        rx_lvl_r;
  logic [9:0]  to_cnt_r;
  logic        to_flag, lsr_err, rda, tx_holding_empty_cond;
  logic [4:0]  tx_lvl, rx_lvl;

  assign divisor_latch_access   = lcr_r[7];
  assign div    = {dlm_r, dll_r};
  assign nbits  = 4'h5 + {2'b00, lcr_r[1:0]};
  assign dmask  = 8'hFF >> (4'h8 - nbits);
  assign wr_thr = wr && addr == OFS_BUF && !divisor_latch_access;
  assign wr_fcr = wr && addr == OFS_IIR;
  assign rd_rbr = rd && addr == OFS_BUF && !divisor_latch_access;
  assign rd_lsr = rd && addr == OFS_LSR;
  assign rx_clr = wr_fcr && (wdata[1] || wdata[0] != fifo_en_r);
  assign tx_clr = wr_fcr && (wdata[2] || wdata[0] != fifo_en_r);

  // software-visible registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcr_r     <= LCR_RST;
      dll_r     <= DIV_RST;
      dlm_r     <= DIV_RST;
      ier_r     <= 8'h00;
      scr_r     <= 8'h00;
      mcr_r     <= 2'h0;
      fifo_en_r <= 1'b0;
      tet_r     <= 2'h0;
      trig_r    <= 2'h0;
    end else if (wr) begin
      unique case (addr)
        OFS_BUF: if (divisor_latch_access) begin
          dll_r <= wdata;
        end
        OFS_IER: if (divisor_latch_access) begin
          dlm_r <= wdata;
        end else begin
          ier_r <= wdata & IER_WMASK;
        end
        OFS_IIR: begin
          fifo_en_r <= wdata[0];
          tet_r     <= wdata[5:4];
          trig_r    <= wdata[7:6];
        end
        OFS_LCR: lcr_r <= wdata;
        OFS_MCR: mcr_r <= wdata[1:0];
        OFS_LSR, OFS_MSR: begin
        end
        OFS_SCR: scr_r <= wdata;
      endcase
    end
  end

  // sixteen ticks per bit, one every div clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div == 16'h0000) begin
      bcnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (bcnt_r >= div - 16'h0001) begin
      bcnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      bcnt_r <= bcnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // without FIFO mode each side holds a single character
  assign tx_iv  = wr_thr && (fifo_en_r || tx_cnt == '0);
  assign tx_pop = tick_r && tx_st_r == ST_IDLE && tx_ov;
  assign rx_iv  = rx_push && (fifo_en_r || rx_cnt == '0);
  assign overrun = rx_push && !(rx_iv && rx_ir);

  suart_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(clk), .rst_n(rst_n), .clr(tx_clr), .in_valid(tx_iv), .in_ready(tx_ir),
    .in_data(wdata), .out_valid(tx_ov), .out_ready(tx_pop), .out_data(tx_od),
    .count(tx_cnt));

  suart_fifo #(.WIDTH(10), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(clk), .rst_n(rst_n), .clr(rx_clr), .in_valid(rx_iv), .in_ready(rx_ir),
    .in_data({!rx_lvl_r, rx_pe_r, 8'(rx_sh_r >> (4'h8 - nbits))}),
    .out_valid(rx_ov), .out_ready(rd_rbr), .out_data(rx_od), .count(rx_cnt));

  // transmitter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r    <= ST_IDLE;
      tx_cnt_r   <= 4'h0;
      tx_bit_r   <= 4'h0;
      tx_sh_r    <= 8'h00;
      tx_par_r   <= 1'b0;
      tx_stop2_r <= 1'b0;
    end else if (tick_r) begin
      tx_cnt_r <= (tx_st_r == ST_IDLE) ? 4'h0 : tx_cnt_r + 4'h1;
      unique case (tx_st_r)
        ST_IDLE: if (tx_ov) begin
          tx_sh_r  <= tx_od;
          tx_par_r <= ^(tx_od & dmask) ^ !lcr_r[4];
          tx_st_r  <= ST_START;
        end
        ST_START: if (tx_cnt_r == OVS_LAST) begin
          tx_st_r  <= ST_DATA;
          tx_bit_r <= 4'h0;
        end
        ST_DATA: if (tx_cnt_r == OVS_LAST) begin
          tx_sh_r  <= tx_sh_r >> 1;
          tx_bit_r <= tx_bit_r + 4'h1;
          if (tx_bit_r == nbits - 4'h1) begin
            tx_st_r    <= lcr_r[3] ? ST_PAR : ST_STOP;
            tx_stop2_r <= 1'b0;
          end
        end
        ST_PAR: if (tx_cnt_r == OVS_LAST) begin
          tx_st_r <= ST_STOP;
        end
        ST_STOP: if (tx_cnt_r == OVS_LAST) begin
          if (lcr_r[2] && !tx_stop2_r) begin
            tx_stop2_r <= 1'b1;
          end else begin
            tx_st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_r <= 1'b1;
    end else begin
      unique case (tx_st_r)
        ST_START: txd_r <= 1'b0;
        ST_DATA:  txd_r <= tx_sh_r[0];
        ST_PAR:   txd_r <= tx_par_r;
        ST_IDLE, ST_STOP: txd_r <= 1'b1;
      endcase
    end
  end

  // receive pin: three flops, level moves when the last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s_r   <= 3'h7;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s_r <= {rx_s_r[1:0], rx_pin};
      if (rx_s_r[1] == rx_s_r[2]) begin
        rx_lvl_r <= rx_s_r[2];
      end
    end
  end

  assign rx_push = tick_r && rx_st_r == ST_STOP && rx_cnt_r == OVS_LAST;

  // receiver: start verified at mid, later bits every sixteen ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r  <= ST_IDLE;
      rx_cnt_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r  <= 8'h00;
      rx_par_r <= 1'b0;
      rx_pe_r  <= 1'b0;
    end else if (tick_r) begin
      rx_cnt_r <= rx_cnt_r + 4'h1;
      unique case (rx_st_r)
        ST_IDLE: if (!rx_lvl_r) begin
          rx_st_r  <= ST_START;
          rx_cnt_r <= 4'h0;
        end
        ST_START: if (rx_cnt_r == OVS_MID) begin
          rx_st_r  <= rx_lvl_r ? ST_IDLE : ST_DATA;
          rx_cnt_r <= 4'h0;
          rx_bit_r <= 4'h0;
          rx_par_r <= 1'b0;
          rx_pe_r  <= 1'b0;
        end
        ST_DATA: if (rx_cnt_r == OVS_LAST) begin
          rx_sh_r  <= {rx_lvl_r, rx_sh_r[7:1]};
          rx_par_r <= rx_par_r ^ rx_lvl_r;
          rx_bit_r <= rx_bit_r + 4'h1;
          if (rx_bit_r == nbits - 4'h1) begin
            rx_st_r <= lcr_r[3] ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: if (rx_cnt_r == OVS_LAST) begin
          rx_pe_r <= (rx_par_r ^ rx_lvl_r) == lcr_r[4];
          rx_st_r <= ST_STOP;
        end
        ST_STOP: if (rx_cnt_r == OVS_LAST) begin
          rx_st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // overrun is sticky until the status read; a new overrun wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_r <= 1'b0;
    end else if (overrun) begin
      oe_r <= 1'b1;
    end else if (rd_lsr) begin
      oe_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt_r <= 10'h000;
    end else if (!fifo_en_r || rx_cnt == '0 || rx_push || rd_rbr) begin
      to_cnt_r <= 10'h000;
    end else if (tick_r && to_cnt_r != TO_TICKS) begin
      to_cnt_r <= to_cnt_r + 10'h001;
    end
  end

  assign to_flag = fifo_en_r && to_cnt_r == TO_TICKS;
  assign lsr_err = oe_r || (rx_ov && (rx_od[8] || rx_od[9]));

  always_comb begin
    unique case (tet_r)
      2'h0: tx_lvl = TET_LVL0;
      2'h1: tx_lvl = TET_LVL1;
      2'h2: tx_lvl = TET_LVL2;
      2'h3: tx_lvl = TET_LVL3;
    endcase
    unique case (trig_r)
      2'h0: rx_lvl = TRIG_LVL0;
      2'h1: rx_lvl = TRIG_LVL1;
      2'h2: rx_lvl = TRIG_LVL2;
      2'h3: rx_lvl = TRIG_LVL3;
    endcase
    rda = fifo_en_r ? (rx_cnt >= CW'(rx_lvl)) : (rx_cnt != '0);
    tx_holding_empty_cond = (ier_r[7] && fifo_en_r) ? (tx_cnt <= CW'(tx_lvl))
                                        : (tx_cnt == '0);
    if (ier_r[2] && lsr_err) begin
      iid = IID_RLS;
    end else if (ier_r[0] && rda) begin
      iid = IID_RDA;
    end else if (ier_r[0] && to_flag) begin
      iid = IID_CTO;
    end else if (ier_r[1] && tx_holding_empty_cond) begin
      iid = IID_TX_HOLDING_EMPTY;
    end else begin
      iid = IID_NONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= iid != IID_NONE;
    end
  end

  // only MCR bit 1 loops back internally, to MSR bit 4; no handshake line reaches a pin
  always_comb begin
    unique case (addr)
      OFS_BUF: rdata = divisor_latch_access ? dll_r : (rx_ov ? rx_od[7:0] : 8'h00);
      OFS_IER: rdata = divisor_latch_access ? dlm_r : ier_r;
      OFS_IIR: rdata = {fifo_en_r, fifo_en_r, 2'h0, iid};
      OFS_LCR: rdata = lcr_r;
      OFS_MCR: rdata = {6'h00, mcr_r};
      OFS_LSR: rdata = {1'b0, tx_cnt == '0 && tx_st_r == ST_IDLE, tx_cnt == '0, 1'b0,
                        rx_ov && rx_od[9], rx_ov && rx_od[8], oe_r, rx_ov};
      OFS_MSR: rdata = {3'h0, mcr_r[1], 4'h0};
      OFS_SCR: rdata = scr_r;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_idle2;
    tx_st_r == ST_IDLE [*2];
  endsequence

  a_div_zero_idle: assert property (div == 16'h0000 |=> !tick_r)
    else $error("baud tick with zero divisor");
  a_tick_spacing: assert property ((tick_r && div > 16'h0001) |=> !tick_r)
    else $error("baud ticks too close");
  a_line_idle_hi: assert property (s_idle2 |-> txd_r)
    else $error("line not high while idle");
  a_start_low: assert property ($past(tx_st_r) == ST_START && tx_st_r == ST_START |-> !txd_r)
    else $error("start bit not low");
  a_timeout_mode: assert property (iid == IID_CTO |-> fifo_en_r)
    else $error("timeout outside FIFO mode");
  a_irq_gate: assert property (irq_r |-> $past(ier_r[2:0]) != 3'h0)
    else $error("interrupt without enable");
  a_divisor_latch_access_map: assert property ((wr && divisor_latch_access && addr == OFS_IER) |=> $stable(ier_r))
    else $error("divisor high write reached interrupt enables");
  a_quarter_lvl: assert property ((ier_r[7] && ier_r[1] && fifo_en_r && tet_r == 2'h2
                                   && tx_cnt == CW'(4) && !lsr_err && !rda && !to_flag)
                                  |-> iid == IID_TX_HOLDING_EMPTY)
    else $error("quarter threshold not raised");
  a_iir_field: assert property ((rd && !wr && addr == OFS_IIR)
                                |=> $stable({fifo_en_r, tet_r, trig_r}))
    else $error("source read changed FIFO control");
endmodule

module suart_top import suart_pkg::*; #(
  parameter int DEPTH = 16
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [1:0] reg_wr,
  input  wire logic [1:0] reg_rd,
  output logic      [7:0] reg_rdata,
  output logic      [1:0] irq,
  input  wire logic       serial_rx_pin,
  output logic            serial_tx_pin,
  input  wire logic       second_serial_rx_pin,
  output logic            second_serial_tx_pin
);
  logic [1:0] rst_sync_r;
  logic [7:0] ch_rdata [2];
  logic [1:0] rx_pins;
  logic [1:0] tx_pins;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rx_pins              = {second_serial_rx_pin, serial_rx_pin};
  assign serial_tx_pin        = tx_pins[0];
  assign second_serial_tx_pin = tx_pins[1];

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    suart_chan #(.DEPTH(DEPTH)) u_chan (
      .clk(ref_clk), .rst_n(rst_sync_r[1]), .addr(reg_addr), .wdata(reg_wdata),
      .wr(reg_wr[ch]), .rd(reg_rd[ch]), .rdata(ch_rdata[ch]), .rx_pin(rx_pins[ch]),
      .txd_r(tx_pins[ch]), .irq_r(irq[ch]));
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd[0]) begin
      reg_rdata <= ch_rdata[0];
    end else if (reg_rd[1]) begin
      reg_rdata <= ch_rdata[1];
    end
  end
endmodule

`default_nettype wire

// ### tb/suart_peer.sv
// Purpose: far-end serial device facing channel one of the controller
// Assumes: bench sets frame format and bit length in ref_clk cycles
// Notes:   frames heard on the tx line are queued with parity and stop bits
`timescale 1ns/1ps
`default_nettype none
module suart_peer (
  input  wire logic clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  int         bit_clks = 16;
  int         nbits    = 8;
  bit         par_en   = 1'b0;
  bit         par_even = 1'b0;
  int         stops    = 1;
  logic [9:0] heard_q[$];
  longint     start_q[$];
  longint     cyc      = 0;

  always @(posedge clk) cyc <= cyc + 1;

  initial rx_line = 1'b1;  // idle high

  task automatic bit_out(input logic b);
    rx_line <= b;
    repeat (bit_clks) @(negedge clk);
  endtask

  // bad_par and bad_stop corrupt one frame on purpose
  task automatic send(input logic [7:0] d, input bit bad_par, input bit bad_stop);
    logic [7:0] m;
    m = d & (8'hFF >> (8 - nbits));
    @(negedge clk);
    bit_out(1'b0);  // start low
    for (int i = 0; i < nbits; i++) bit_out(m[i]);  // lsb first
    if (par_en) bit_out((^m) ^ !par_even ^ bad_par);
    bit_out(!bad_stop);
    for (int i = 1; i < stops; i++) bit_out(1'b1);
    rx_line <= 1'b1;
  endtask

  initial begin : listen
    logic [7:0] d;
    logic       p;
    logic       s;
    longint     t0;
    forever begin
      @(negedge tx_line);
      t0 = cyc;
      repeat (bit_clks / 2) @(posedge clk);
      if (tx_line === 1'b0) begin
        d = 8'h00;
        p = 1'b0;
        for (int i = 0; i < nbits; i++) begin
          repeat (bit_clks) @(posedge clk);
          d[i] = tx_line;
        end
        if (par_en) begin
          repeat (bit_clks) @(posedge clk);
          p = tx_line;
        end
        repeat (bit_clks) @(posedge clk);
        s = tx_line;
        heard_q.push_back({s, p, d});
        start_q.push_back(t0);
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/system_uart_with_fifos_tb.sv
// Purpose: self-checking bench for the dual serial controller
// Assumes: divisor 1 or 2 keeps frames short; channel two is looped back
// Notes:   strobes and the peer line change on falling edges
`timescale 1ns/1ps
`default_nettype none
module system_uart_with_fifos_tb import suart_pkg::*; ;
  localparam logic [7:0] FMT [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0B, 8'h1B, 8'h07, 8'h1C};
  logic       ref_clk   = 1'b0;
  logic       arst_n    = 1'b1;
  logic [2:0] reg_addr  = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] reg_wr    = 2'h0;
  logic [1:0] reg_rd    = 2'h0;
  logic [7:0] reg_rdata;
  logic [1:0] irq;
  logic       rx0;
  logic       tx0;
  logic       loop1;
  int         n_errors  = 0;
  int         cmp_count = 0;

  always #4 ref_clk = ~ref_clk;

  suart_top #(.DEPTH(16)) u_suart_top (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .serial_rx_pin(rx0), .serial_tx_pin(tx0),
    .second_serial_rx_pin(loop1), .second_serial_tx_pin(loop1));

  // peer drives an idle-high line before any channel is configured
  suart_peer u_suart_peer (.clk(ref_clk), .tx_line(tx0), .rx_line(rx0));

  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr   = a;
    reg_wdata  = d;
    reg_wr[ch] = 1'b1;
    @(negedge ref_clk);
    reg_wr = 2'h0;
  endtask

  task automatic rchk(input int ch, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr   = a;
    reg_rd[ch] = 1'b1;
    @(negedge ref_clk);
    reg_rd = 2'h0;
    @(negedge ref_clk);
    check(16'(reg_rdata & m), 16'(e));
  endtask

  task automatic setup(input int ch, input logic [7:0] dv, input logic [7:0] line_control_reg);
    wr(ch, OFS_LCR, 8'h80 | line_control_reg);
    wr(ch, OFS_BUF, dv);
    wr(ch, OFS_IER, 8'h00);
    wr(ch, OFS_LCR, line_control_reg);
  endtask

  task automatic peer_fmt(input logic [7:0] line_control_reg, input int bc);
    u_suart_peer.bit_clks = bc;
    u_suart_peer.nbits    = 5 + int'(line_control_reg[1:0]);
    u_suart_peer.par_en   = line_control_reg[3];
    u_suart_peer.par_even = line_control_reg[4];
    u_suart_peer.stops    = line_control_reg[2] ? 2 : 1;
    u_suart_peer.heard_q.delete();
    u_suart_peer.start_q.delete();
  endtask

  function automatic logic [9:0] frm(input logic [7:0] line_control_reg, input logic [7:0] d);
    logic [7:0] m;
    m = d & (8'hFF >> (3 - line_control_reg[1:0]));
    return {1'b1, line_control_reg[3] & ((^m) ^ !line_control_reg[4]), m};
  endfunction

  task automatic heard(input int i, input logic [9:0] e);
    check(16'(u_suart_peer.heard_q[i]), 16'(e));
  endtask

  task automatic wait_irq(input int ch, input int max);
    for (int i = 0; i < max && irq[ch] !== 1'b1; i++) @(negedge ref_clk);
  endtask

  task automatic t_reset();
    for (int ch = 0; ch < 2; ch++) begin
      rchk(ch, OFS_LCR, 8'hFF, LCR_RST);
      rchk(ch, OFS_IIR, 8'hFF, 8'h01);
      wr(ch, OFS_LCR, 8'h80);
      rchk(ch, OFS_BUF, 8'hFF, DIV_RST);
      rchk(ch, OFS_IER, 8'hFF, DIV_RST);
    end
    check(16'({irq, tx0}), 16'h1);
  endtask

  task automatic t_divisor_latch_access();
    setup(0, 8'h5A, 8'h03);
    wr(0, OFS_IER, 8'h87);
    rchk(0, OFS_IER, 8'hFF, 8'h87);
    wr(0, OFS_LCR, 8'h83);
    rchk(0, OFS_BUF, 8'hFF, 8'h5A);
    rchk(0, OFS_IER, 8'hFF, 8'h00);
    setup(0, 8'h00, 8'h03);
    wr(0, OFS_IER, 8'h00);
    wr(0, OFS_MCR, 8'h03);
    rchk(0, OFS_MCR, 8'hFF, 8'h03);
    rchk(0, OFS_MSR, 8'hFF, 8'h10);
    check(16'(tx0), 16'h1);
    wr(0, OFS_SCR, 8'hC9);
    rchk(0, OFS_SCR, 8'hFF, 8'hC9);
  endtask

  task automatic t_txfill();
    peer_fmt(8'h03, 16);
    wr(0, OFS_IIR, 8'h07);
    for (int i = 0; i < 17; i++) wr(0, OFS_BUF, 8'h30 + 8'(i));
    cycles(400);
    check(16'(u_suart_peer.heard_q.size()), 16'h0);
    rchk(0, OFS_LSR, 8'h20, 8'h00);
    setup(0, 8'h01, 8'h03);
    cycles(17 * 160 + 200);
    check(16'(u_suart_peer.heard_q.size()), 16'h10);
    for (int i = 0; i < 16; i++) heard(i, {2'b10, 8'h30 + 8'(i)});
  endtask

  task automatic t_formats();
    int     fl;
    longint gap;
    foreach (FMT[k]) begin
      peer_fmt(FMT[k], 32);
      setup(0, 8'h02, FMT[k]);
      fl = (6 + int'(FMT[k][1:0]) + int'(FMT[k][3]) + (FMT[k][2] ? 2 : 1)) * 32;
      wr(0, OFS_BUF, 8'hA5);
      wr(0, OFS_BUF, 8'h3C);
      cycles(2 * fl + 100);
      heard(0, frm(FMT[k], 8'hA5));
      heard(1, frm(FMT[k], 8'h3C));
      gap = u_suart_peer.start_q[1] - u_suart_peer.start_q[0];
      check(16'(gap >= fl && gap <= fl + 16), 16'h1);
    end
  endtask

  task automatic t_rx();
    setup(0, 8'h01, 8'h03);
    peer_fmt(8'h03, 16);
    wr(0, OFS_IIR, 8'h07);
    u_suart_peer.send(8'hC3, 1'b0, 1'b0);
    cycles(20);
    check(16'(irq[0]), 16'h0);
    rchk(0, OFS_LSR, 8'h01, 8'h01);
    wr(0, OFS_IER, 8'h01);
    cycles(3);
    check(16'(irq[0]), 16'h1);
    rchk(0, OFS_IIR, 8'hFF, 8'hC4);
    rchk(0, OFS_BUF, 8'hFF, 8'hC3);
    cycles(3);
    check(16'(irq[0]), 16'h0);
  endtask

  task automatic t_errors();
    setup(0, 8'h01, 8'h1B);
    peer_fmt(8'h1B, 16);
    wr(0, OFS_IIR, 8'h07);
    wr(0, OFS_IER, 8'h05);
    u_suart_peer.send(8'h96, 1'b1, 1'b0);
    cycles(20);
    rchk(0, OFS_IIR, 8'hFF, 8'hC6);
    rchk(0, OFS_LSR, 8'h0C, 8'h04);
    rchk(0, OFS_BUF, 8'hFF, 8'h96);
    u_suart_peer.send(8'h55, 1'b0, 1'b1);
    cycles(20);
    rchk(0, OFS_LSR, 8'h0C, 8'h08);
    rchk(0, OFS_BUF, 8'hFF, 8'h55);
  endtask

  task automatic t_overrun();
    setup(0, 8'h01, 8'h03);
    peer_fmt(8'h03, 16);
    wr(0, OFS_IIR, 8'h07);
    for (int i = 0; i < 17; i++) u_suart_peer.send(8'h40 + 8'(i), 1'b0, 1'b0);
    cycles(20);
    rchk(0, OFS_LSR, 8'h03, 8'h03);
    for (int i = 0; i < 16; i++) rchk(0, OFS_BUF, 8'hFF, 8'h40 + 8'(i));
    rchk(0, OFS_LSR, 8'h03, 8'h00);
    rchk(0, OFS_BUF, 8'hFF, 8'h00);
  endtask

  task automatic t_timeout();
    wr(0, OFS_IIR, 8'h47);
    wr(0, OFS_IER, 8'h01);
    u_suart_peer.send(8'h11, 1'b0, 1'b0);
    cycles(20);
    check(16'(irq[0]), 16'h0);
    wait_irq(0, 1000);
    check(16'(irq[0]), 16'h1);
    rchk(0, OFS_IIR, 8'hFF, 8'hCC);
    rchk(0, OFS_BUF, 8'hFF, 8'h11);
    wr(0, OFS_IIR, 8'h00);
    u_suart_peer.send(8'h22, 1'b0, 1'b0);
    cycles(900);
    rchk(0, OFS_IIR, 8'hFF, 8'h04);
    rchk(0, OFS_BUF, 8'hFF, 8'h22);
  endtask

  task automatic t_tx_holding_empty();
    setup(0, 8'h00, 8'h03);
    wr(0, OFS_IIR, 8'h27);
    wr(0, OFS_IER, 8'h02);
    for (int i = 0; i < 4; i++) wr(0, OFS_BUF, 8'(i));
    cycles(3);
    check(16'(irq[0]), 16'h0);
    wr(0, OFS_IER, 8'h82);
    cycles(3);
    check(16'(irq[0]), 16'h1);
    rchk(0, OFS_IIR, 8'hFF, 8'hC2);
    wr(0, OFS_BUF, 8'h04);
    wr(0, OFS_BUF, 8'h05);
    cycles(3);
    check(16'(irq[0]), 16'h0);
    rchk(0, OFS_IIR, 8'hFF, 8'hC1);
    wr(0, OFS_IIR, 8'h27);
    cycles(3);
    check(16'(irq[0]), 16'h1);
    wr(0, OFS_IER, 8'h00);
    cycles(3);
    check(16'(irq[0]), 16'h0);
  endtask

  task automatic t_chan2();
    peer_fmt(8'h03, 16);
    setup(1, 8'h01, 8'h1B);
    wr(1, OFS_IIR, 8'h07);
    wr(1, OFS_IER, 8'h01);
    wr(1, OFS_BUF, 8'hA7);
    wait_irq(1, 400);
    check(16'(irq), 16'h2);
    rchk(1, OFS_BUF, 8'hFF, 8'hA7);
    rchk(0, OFS_LCR, 8'hFF, 8'h03);
    check(16'(u_suart_peer.heard_q.size()), 16'h0);
  endtask

  initial begin
    // assert reset before the first edge so no flop with a reset starts unknown
    #2 arst_n = 1'b0;
    cycles(10);
    arst_n = 1'b1;
    cycles(5);
    t_reset();
    t_divisor_latch_access();
    t_txfill();
    t_formats();
    t_rx();
    t_errors();
    t_overrun();
    t_timeout();
    t_tx_holding_empty();
    t_chan2();
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
